// [include/pidr_pkg.sv]
`default_nettype none
package pidr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus addressing
  localparam logic [6:0] STORE_CTRL_ID = 7'h57;
  localparam logic [7:0] STORE_LO      = 8'hF0;
  localparam logic [7:0] STORE_HI      = 8'hF7;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // identifier layout
  localparam int         FIFO_DEPTH    = 8;
  localparam int         STORE_BYTES   = 8;
  localparam logic [2:0] OUI48_BASE    = 3'h2;
  localparam logic [7:0] BLANK_BYTE    = 8'hFF;
  localparam logic [15:0] WRAP48_MARK  = 16'hFFFE;
  localparam logic [15:0] WRAP48_ALT   = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // target states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_CTRL = 7'h02,
    S_ACKC = 7'h04,
    S_ADDR = 7'h08,
    S_ACKA = 7'h10,
    S_TX   = 7'h20,
    S_RACK = 7'h40
  } pidr_state_t;

  function automatic logic in_store(input logic [7:0] a);
    return (a >= STORE_LO) && (a <= STORE_HI);
  endfunction

  // inside the store only the low three bits count, so F7 rolls to F0
  function automatic logic [7:0] ptr_next(input logic [7:0] a);
    if (in_store(a))
      return {a[7:3], 3'(a[2:0] + 3'h1)};
    return 8'(a + 8'h01);
  endfunction

endpackage
`default_nettype wire

// [include/pidr_fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pidr_fifo_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] in_data;
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] out_data;
  logic             out_valid;
  logic             out_ready;
  logic             clear;

  modport fifo (input in_data, in_valid, out_ready, clear,
                output in_ready, out_data, out_valid);
  modport user (output in_data, in_valid, out_ready, clear,
                input in_ready, out_data, out_valid);
endinterface
`default_nettype wire

// [verilog/pidr_id_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module pidr_id_mem #(
  parameter bit          VARIANT_64 = 1'b1,
  parameter logic [23:0] ORG_ID     = 24'h12_3456, // arbitrary value
  parameter logic [39:0] EXT_ID     = 40'h01_2345_6789 // arbitrary value
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // read port
  input  wire logic       rd_en,
  input  wire logic [2:0] rd_addr,
  output logic      [7:0] rd_data,
  output logic            rd_valid
);

  logic [7:0] rom [pidr_pkg::STORE_BYTES];
  logic [7:0] next_rd_data;

  //////////////////////////////////////////////////////////////////////////////
  // factory image, one generate entry per location
  for (genvar i = 0; i < pidr_pkg::STORE_BYTES; i++)
  begin : g_loc
    localparam logic [63:0] IMG64 = {ORG_ID, EXT_ID};
    localparam logic [63:0] IMG48 = {pidr_pkg::BLANK_BYTE,
                                     pidr_pkg::BLANK_BYTE,
                                     ORG_ID, EXT_ID[23:0]};
    if (VARIANT_64)
    begin : g_64
      assign rom[i] = IMG64[63-8*i -: 8];
    end
    else
    begin : g_48
      assign rom[i] = IMG48[63-8*i -: 8];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered read, no unlock needed to read
  always_comb
  begin
    next_rd_data = rd_data;
    if (rd_en)
      next_rd_data = rom[rd_addr];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_data  <= next_rd_data;
      rd_valid <= rd_en;
    end
  end

  chk_ext_reserved: assert property (@(posedge clock)
    !(VARIANT_64 && ({rom[3], rom[4]} == pidr_pkg::WRAP48_MARK ||
                     {rom[3], rom[4]} == pidr_pkg::WRAP48_ALT)))
    else $error("reserved pattern in extension bytes");

endmodule // pidr_id_mem
`default_nettype wire

// [verilog/pidr_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module pidr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = pidr_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // both sides
  pidr_fifo_if.fifo f
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             do_push, do_pop;

  assign f.in_ready  = (count != (AW+1)'(DEPTH));
  assign f.out_valid = (count != '0);
  assign f.out_data  = mem[rd_ptr];
  assign do_push     = f.in_valid && f.in_ready && !f.clear;
  assign do_pop      = f.out_valid && f.out_ready && !f.clear;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (f.clear)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
    else
    begin
      if (do_push)
        next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
      if (do_pop)
        next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
      next_count = (AW+1)'(count + do_push - do_pop);
    end
  end

  always_ff @(posedge clock)
  begin
    if (do_push)
      mem[wr_ptr] <= f.in_data;
    if (srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

endmodule // pidr_fifo
`default_nettype wire

// [verilog/pidr_top.sv]
// How it works
// - pointer holds last accessed location plus one for current-address reads.
// - store control byte with read bit is acknowledged, then one byte out.
// - master nacks then stops; the target releases data after the nack, without waiting for the stop.
// - one pointer shared with register space; its loads and steps move it except in a cycle where the bus updates it.
// - location byte loads the pointer at its acknowledge, before any restart.
// - after a random read the pointer is past the byte returned.
// - master ack after a byte makes the target send the next location.
// - pointer steps by one at every completed byte sent.
// - stepping past the top store location wraps to the first.
// - six-byte identifier sits in the upper six locations.
// - eight-byte identifier fills all eight locations.
// - factory long identifier never holds the reserved extension patterns.
// - store answers only to its own control-byte pattern.
// - location outside the store range is not acknowledged.
// - reads work without any unlock sequence.
// - no control byte acknowledge while a nonvolatile write runs.
`timescale 1ns/1ps
`default_nettype none
module pidr_top #(
  parameter bit          VARIANT_64 = 1'b1,
  parameter logic [23:0] ORG_ID     = 24'h12_3456, // arbitrary value
  parameter logic [39:0] EXT_ID     = 40'h01_2345_6789 // arbitrary value
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // two-wire bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // shared pointer with register space
  input  wire logic       nv_busy,
  input  wire logic       ptr_load,
  input  wire logic [7:0] ptr_load_val,
  input  wire logic       ptr_step,
  output logic      [7:0] ptr
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change accepted once stages two and three agree
  logic [2:0] scl_s, sda_s;
  logic       scl_f, sda_f, scl_q, sda_q;
  logic       next_scl_f, next_sda_f;

  always_comb
  begin
    next_scl_f = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
    next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
  end
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_f && !scl_q;
  assign scl_fall  = !scl_f && scl_q;
  assign start_det = scl_f && scl_q && sda_q && !sda_f;
  assign stop_det  = scl_f && scl_q && !sda_q && sda_f;

  //////////////////////////////////////////////////////////////////////////////
  // prefetch path: store -> fifo -> shifter
  pidr_fifo_if #(.WIDTH(8)) fq ();
  logic       rd_en, rd_valid, pend, fetch_on, fetch_start;
  logic       next_pend, next_fetch_on;
  logic [2:0] fetch_addr, next_fetch_addr;
  logic [7:0] rd_data;
  logic       pop;
  pidr_id_mem #(
    .VARIANT_64 (VARIANT_64),
    .ORG_ID     (ORG_ID),
    .EXT_ID     (EXT_ID)
  ) u_mem (
    .clock    (clock),
    .srst     (srst),
    .rd_en    (rd_en),
    .rd_addr  (fetch_addr),
    .rd_data  (rd_data),
    .rd_valid (rd_valid)
  );
  pidr_fifo #(
    .WIDTH (8),
    .DEPTH (pidr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .srst  (srst),
    .f     (fq)
  );

  // fetcher stalls on fifo back-pressure, one read in flight
  assign rd_en        = fetch_on && fq.in_ready && !pend && !fetch_start;
  assign fq.in_data   = rd_data;
  assign fq.in_valid  = rd_valid && fetch_on;
  assign fq.out_ready = pop;
  assign fq.clear     = fetch_start || start_det || stop_det;
  always_comb
  begin
    next_pend       = rd_en;
    next_fetch_on   = fetch_on;
    next_fetch_addr = fetch_addr;
    if (start_det || stop_det)
      next_fetch_on = 1'b0;
    else if (fetch_start)
    begin
      next_fetch_on   = 1'b1;
      next_fetch_addr = ptr[2:0];
    end
    else if (rd_en)
      next_fetch_addr = 3'(fetch_addr + 3'h1);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pend       <= 1'b0;
      fetch_on   <= 1'b0;
      fetch_addr <= 3'h0;
    end
    else
    begin
      pend       <= next_pend;
      fetch_on   <= next_fetch_on;
      fetch_addr <= next_fetch_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus target state machine
  pidr_pkg::pidr_state_t st, next_st;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] sh, next_sh, next_ptr;
  logic       rw, next_rw, cont, next_cont, next_oe, int_upd;
  logic       ctrl_hit, addr_hit, byte_done;
  assign ctrl_hit  = (sh[7:1] == pidr_pkg::STORE_CTRL_ID) && !nv_busy;
  assign addr_hit  = pidr_pkg::in_store(sh);
  assign byte_done = scl_fall && (bitcnt == pidr_pkg::BITS_PER_BYTE);
  assign sda_out   = 1'b0;
  always_comb
  begin
    next_st     = st;
    next_bitcnt = bitcnt;
    next_sh     = sh;
    next_oe     = sda_oe;
    next_rw     = rw;
    next_cont   = cont;
    next_ptr    = ptr;
    int_upd     = 1'b0;
    pop         = 1'b0;
    fetch_start = 1'b0;
    if (start_det)
    begin
      next_st     = pidr_pkg::S_CTRL;
      next_bitcnt = 4'h0;
      next_oe     = 1'b0;
    end
    else if (stop_det)
    begin
      next_st = pidr_pkg::S_IDLE;
      next_oe = 1'b0;
    end
    else
    begin
      unique case (st)
        pidr_pkg::S_IDLE: ;
        pidr_pkg::S_CTRL, pidr_pkg::S_ADDR:
        begin
          if (scl_rise && bitcnt != pidr_pkg::BITS_PER_BYTE)
          begin
            next_sh     = {sh[6:0], sda_f};
            next_bitcnt = 4'(bitcnt + 4'h1);
          end
          if (byte_done && st == pidr_pkg::S_CTRL)
          begin
            if (ctrl_hit)
            begin
              next_st     = pidr_pkg::S_ACKC;
              next_oe     = 1'b1;
              next_rw     = sh[0];
              fetch_start = sh[0];
            end
            else
              next_st = pidr_pkg::S_IDLE;
          end
          else if (byte_done)
          begin
            if (addr_hit)
            begin
              next_st  = pidr_pkg::S_ACKA;
              next_oe  = 1'b1;
              next_ptr = sh;
              int_upd  = 1'b1;
            end
            else
              next_st = pidr_pkg::S_IDLE;
          end
        end
        pidr_pkg::S_ACKC, pidr_pkg::S_RACK:
        begin
          if (scl_rise && st == pidr_pkg::S_RACK)
            next_cont = !sda_f;
          if (scl_fall && st == pidr_pkg::S_ACKC && !rw)
          begin
            next_st     = pidr_pkg::S_ADDR;
            next_oe     = 1'b0;
            next_bitcnt = 4'h0;
          end
          else if (scl_fall && (st == pidr_pkg::S_ACKC || cont))
          begin
            next_st     = pidr_pkg::S_TX;
            next_sh     = fq.out_data;
            next_oe     = !fq.out_data[7];
            next_bitcnt = 4'h1;
            pop         = 1'b1;
          end
          else if (scl_fall)
          begin
            next_st = pidr_pkg::S_IDLE;
            next_oe = 1'b0;
          end
        end
        pidr_pkg::S_ACKA:
        begin
          if (scl_fall)
          begin
            next_st = pidr_pkg::S_IDLE;
            next_oe = 1'b0;
          end
        end
        pidr_pkg::S_TX:
        begin
          if (byte_done)
          begin
            next_st   = pidr_pkg::S_RACK;
            next_oe   = 1'b0;
            next_cont = 1'b0;
            next_ptr  = pidr_pkg::ptr_next(ptr);
            int_upd   = 1'b1;
          end
          else if (scl_fall)
          begin
            next_sh     = {sh[6:0], 1'b0};
            next_oe     = !sh[6];
            next_bitcnt = 4'(bitcnt + 4'h1);
          end
        end
      endcase
    end
    if (!int_upd && ptr_load)
      next_ptr = ptr_load_val;
    else if (!int_upd && ptr_step)
      next_ptr = pidr_pkg::ptr_next(ptr);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st     <= pidr_pkg::S_IDLE;
      bitcnt <= 4'h0;
      sh     <= 8'h00;
      sda_oe <= 1'b0;
      rw     <= 1'b0;
      cont   <= 1'b0;
      ptr    <= pidr_pkg::PTR_RESET;
    end
    else
    begin
      st     <= next_st;
      bitcnt <= next_bitcnt;
      sh     <= next_sh;
      sda_oe <= next_oe;
      rw     <= next_rw;
      cont   <= next_cont;
      ptr    <= next_ptr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  chk_ctrl_ack_given: assert property (@(posedge clock) disable iff (srst)
    (st == pidr_pkg::S_CTRL && byte_done && ctrl_hit && !start_det &&
     !stop_det) |=> (sda_oe && st == pidr_pkg::S_ACKC))
    else $error("matching control byte not acknowledged");
  chk_busy_no_ack: assert property (@(posedge clock) disable iff (srst)
    (st == pidr_pkg::S_CTRL && byte_done && nv_busy) |=> !sda_oe)
    else $error("control byte acknowledged while busy");
  chk_addr_range: assert property (@(posedge clock) disable iff (srst)
    (st == pidr_pkg::S_ADDR && byte_done && !addr_hit) |=>
      (!sda_oe && st == pidr_pkg::S_IDLE))
    else $error("out of range location acknowledged");
  chk_ptr_load_addr: assert property (@(posedge clock) disable iff (srst)
    (st == pidr_pkg::S_ADDR && byte_done && addr_hit && !start_det &&
     !stop_det) |=> (ptr == $past(sh)))
    else $error("pointer not loaded from location byte");
  chk_ptr_step_wrap: assert property (@(posedge clock) disable iff (srst)
    (st == pidr_pkg::S_TX && byte_done && pidr_pkg::in_store(ptr) &&
     !start_det && !stop_det) |=>
      (ptr[7:3] == $past(ptr[7:3]) &&
       ptr[2:0] == 3'($past(ptr[2:0]) + 3'h1)))
    else $error("pointer did not step within the store");
  chk_nack_release: assert property (@(posedge clock) disable iff (srst)
    (st == pidr_pkg::S_RACK && scl_fall && !cont && !start_det) |=>
      (!sda_oe && st == pidr_pkg::S_IDLE) [*2])
    else $error("data still driven after master nack");
  chk_seq_next_byte: assert property (@(posedge clock) disable iff (srst)
    (st == pidr_pkg::S_RACK && scl_fall && cont && !start_det &&
     !stop_det) |=> (st == pidr_pkg::S_TX && bitcnt == 4'h1))
    else $error("acknowledged byte not followed by next");
  chk_shared_load: assert property (@(posedge clock) disable iff (srst)
    (ptr_load && !int_upd) |=> (ptr == $past(ptr_load_val)))
    else $error("shared pointer load lost");
  chk_release_between: assert property (@(posedge clock) disable iff (srst)
    stop_det |=> (!sda_oe && st == pidr_pkg::S_IDLE))
    else $error("target still active after stop");

endmodule // pidr_top
`default_nettype wire

// [tb/pidr_i2c_master.sv]
`timescale 1ns/1ps
`default_nettype none
module pidr_i2c_master #(
  parameter int QTR = 10
) (
  // clock
  input  wire logic clock,
  // bus
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_drv
);
  // bus idles released, pulled high
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic pause();
    repeat (QTR) @(negedge clock);
  endtask

  // data moves only while scl is low
  task automatic bit_xfer(input logic b, output logic s);
    sda_drv = b;
    pause();
    scl = 1'b1;
    pause();
    s = sda_line;
    scl = 1'b0;
    pause();
  endtask

  // also serves as repeated start
  task automatic start();
    sda_drv = 1'b1;
    pause();
    scl = 1'b1;
    pause();
    sda_drv = 1'b0;
    pause();
    scl = 1'b0;
    pause();
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    pause();
    scl = 1'b1;
    pause();
    sda_drv = 1'b1;
    pause();
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], s);
    bit_xfer(1'b1, ack);
  endtask

  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(nack, s);
  endtask
endmodule // pidr_i2c_master
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("CHECK FAILED %0t %s", $time, msg); \
    end \
  end
module tb_top;
  localparam logic [23:0] ORG = 24'hA1_B2C3;      // arbitrary value
  localparam logic [39:0] EXT = 40'h10_2030_4050; // arbitrary value
  int         err_count = 0;
  int         checked   = 0;
  logic       clock;
  logic       srst;
  logic       nv_busy;
  logic       ptr_load;
  logic       ptr_step;
  logic [7:0] ptr_load_val;
  logic [7:0] got [16];
  wire logic [7:0] ptr;
  wire logic [7:0] ptr48;
  wire logic  scl, sda_drv, sda_oe, sda_out, sda_line;
  wire logic  scl2, sda_drv2, sda_oe2, sda_out2, sda_line2;

  // open-drain wire with pull-up
  assign sda_line  = sda_drv & (sda_oe ? sda_out : 1'b1);
  assign sda_line2 = sda_drv2 & (sda_oe2 ? sda_out2 : 1'b1);

  pidr_top #(.VARIANT_64(1'b1), .ORG_ID(ORG), .EXT_ID(EXT)) i_pidr_top (
    .clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .nv_busy(nv_busy),
    .ptr_load(ptr_load), .ptr_load_val(ptr_load_val),
    .ptr_step(ptr_step), .ptr(ptr));
  pidr_top #(.VARIANT_64(1'b0), .ORG_ID(ORG), .EXT_ID(EXT)) i_pidr_top_48 (
    .clock(clock), .srst(srst), .scl_in(scl2), .sda_in(sda_line2),
    .sda_out(sda_out2), .sda_oe(sda_oe2), .nv_busy(nv_busy),
    .ptr_load(ptr_load), .ptr_load_val(ptr_load_val),
    .ptr_step(ptr_step), .ptr(ptr48));
  pidr_i2c_master i_pidr_i2c_master (
    .clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  pidr_i2c_master i_pidr_i2c_master_48 (
    .clock(clock), .sda_line(sda_line2), .scl(scl2), .sda_drv(sda_drv2));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp64(input int i);
    logic [63:0] v;
    v = {ORG, EXT};
    return v[63 - 8 * i -: 8];
  endfunction

  function automatic logic [7:0] exp48(input int i);
    logic [47:0] v;
    v = {ORG, EXT[23:0]};
    return (i < 2) ? 8'hFF : v[47 - 8 * (i - 2) -: 8];
  endfunction

  task automatic give_verdict();
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic addr_phase(input logic [7:0] loc, input logic exp_ack);
    logic a;
    i_pidr_i2c_master.start();
    i_pidr_i2c_master.write_byte(8'hAE, a);
    `CHK(a, 1'b0, "write ctrl nack");
    i_pidr_i2c_master.write_byte(loc, a);
    `CHK(a, exp_ack, "location ack");
  endtask

  task automatic read_seq(input int first, input int n);
    logic a;
    i_pidr_i2c_master.start();
    i_pidr_i2c_master.write_byte(8'hAF, a);
    `CHK(a, 1'b0, "read ctrl nack");
    for (int k = 0; k < n; k++)
    begin
      i_pidr_i2c_master.read_byte(k == n - 1, got[k]);
      `CHK(got[k], exp64((first + k) % 8), "data");
    end
    i_pidr_i2c_master.stop();
  endtask

  task automatic pulse(input logic ld, input logic [7:0] v);
    ptr_load     = ld;
    ptr_step     = !ld;
    ptr_load_val = v;
    @(negedge clock);
    ptr_load = 1'b0;
    ptr_step = 1'b0;
    @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_random_current();
    addr_phase(8'hF3, 1'b0);
    `CHK(ptr, 8'hF3, "ptr after location");
    read_seq(3, 1);
    `CHK(ptr, 8'hF4, "ptr after random read");
    `CHK(sda_oe, 1'b0, "still driving");
    read_seq(4, 1);
    `CHK(ptr, 8'hF5, "ptr after current read");
  endtask

  task automatic s_seq_wrap();
    addr_phase(8'hF6, 1'b0);
    read_seq(6, 10);
    `CHK(ptr, 8'hF0, "ptr after wrap");
    `CHK({got[5], got[6]} inside {16'hFFFE, 16'hFFFF}, 1'b0, "ext");
  endtask

  task automatic s_refuse();
    logic        a;
    logic [7:0]  bad [3] = '{8'hDE, 8'hA1, 8'hAC};
    foreach (bad[i])
    begin
      i_pidr_i2c_master.start();
      i_pidr_i2c_master.write_byte(bad[i], a);
      `CHK(a, 1'b1, "foreign ctrl acked");
      i_pidr_i2c_master.stop();
    end
    addr_phase(8'hEF, 1'b1);
    i_pidr_i2c_master.stop();
    addr_phase(8'hF8, 1'b1);
    i_pidr_i2c_master.stop();
    `CHK(ptr, 8'hF0, "ptr moved by refused loc");
    nv_busy = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      i_pidr_i2c_master.start();
      i_pidr_i2c_master.write_byte(8'hAE | 8'(i), a);
      `CHK(a, 1'b1, "ctrl acked while busy");
      i_pidr_i2c_master.stop();
    end
    nv_busy = 1'b0;
    read_seq(0, 1);
  endtask

  task automatic s_shared();
    pulse(1'b1, 8'h1F);
    `CHK(ptr, 8'h1F, "load");
    pulse(1'b0, 8'h00);
    `CHK(ptr, 8'h20, "step outside store");
    pulse(1'b1, 8'hFF);
    pulse(1'b0, 8'h00);
    `CHK(ptr, 8'h00, "step mod 256");
    pulse(1'b1, 8'hF7);
    pulse(1'b0, 8'h00);
    `CHK(ptr, 8'hF0, "step wrap");
    pulse(1'b1, 8'hF2);
    read_seq(2, 1);
    `CHK(ptr, 8'hF3, "ptr after shared read");
  endtask

  task automatic s_v48();
    logic a;
    logic [7:0] b [8];
    i_pidr_i2c_master_48.start();
    i_pidr_i2c_master_48.write_byte(8'hAE, a);
    i_pidr_i2c_master_48.write_byte(8'hF0, a);
    i_pidr_i2c_master_48.start();
    i_pidr_i2c_master_48.write_byte(8'hAF, a);
    `CHK(a, 1'b0, "48 ctrl nack");
    for (int k = 0; k < 8; k++)
    begin
      i_pidr_i2c_master_48.read_byte(k == 7, b[k]);
      `CHK(b[k], exp48(k), "48 data");
    end
    i_pidr_i2c_master_48.stop();
    `CHK(ptr48, 8'hF0, "48 ptr after wrap");
    `CHK({b[2], b[3], b[4], 16'hFFFE, b[5], b[6], b[7]},
         {ORG, 16'hFFFE, EXT[23:0]}, "long form");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    srst         = 1'b1;
    nv_busy      = 1'b0;
    ptr_load     = 1'b0;
    ptr_step     = 1'b0;
    ptr_load_val = 8'h00;
    repeat (12) @(negedge clock);
    srst = 1'b0;
    `CHK(sda_oe, 1'b0, "oe at reset");
    `CHK(ptr, 8'h00, "ptr at reset");
    s_random_current();
    s_seq_wrap();
    s_refuse();
    s_shared();
    s_v48();
    give_verdict();
  end

  initial
  begin
    repeat (60000) @(posedge clock);
    err_count++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
